//--- logic/spi_master_slave_engine.sv
/*
 * Byte-wide full-duplex SPI engine acting as master or slave, with double-buffered
 * transmit, receive buffer, sticky flags and four slave-select configurations.
 * Assumes control words and data strokes come from logic on ref_clk_i, and the
 * SPI pins are asynchronous and resolved from the enables by the surroundings.
 */
`timescale 1ns/1ps
`include "spi_engine_cfg.svh"

module spi_master_slave_engine (
    input  wire logic                          ref_clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          clk_en_i,
    input  wire logic                          ctrl_wr_i,
    input  wire spi_engine_pkg::control_word_s ctrl_i,
    input  wire logic [3:0]                    flag_clr_i,
    input  wire logic                          irq_en_i,
    input  wire logic                          data_wr_i,
    input  wire logic [7:0]                    data_wdata_i,
    input  wire logic                          data_rd_i,
    input  wire logic                          sck_i,
    input  wire logic                          mosi_i,
    input  wire logic                          miso_i,
    input  wire logic                          slave_select_n_i,
    output spi_engine_pkg::control_word_s      ctrl_o,
    output spi_engine_pkg::flags_s             flags_o,
    output logic                               irq_o,
    output logic [7:0]                         rx_data_o,
    output logic                               rx_full_o,
    output logic                               tx_full_o,
    output logic                               busy_o,
    output logic                               selected_o,
    output logic                               sck_o,
    output logic                               sck_oe_o,
    output logic                               mosi_o,
    output logic                               mosi_oe_o,
    output logic                               miso_o,
    output logic                               miso_oe_o,
    output logic                               slave_select_n_o,
    output logic                               slave_select_n_oe_o,
    output logic                               slave_select_mapped_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    spi_engine_pkg::control_word_s ctrl;
    spi_engine_pkg::flags_s        flags;
    spi_engine_pkg::pins_s         pins;
    spi_engine_pkg::master_state_e m_state;
    logic [7:0]                    tx_buf;
    logic                          tx_full;
    logic [7:0]                    sr;
    logic                          sr_empty;
    logic [7:0]                    rx_buf;
    logic                          rx_full;
    logic [3:0]                    edge_cnt;
    logic [7:0]                    div_cnt;
    logic                          sck_lvl;
    logic                          samp;
    logic                          sck_d;
    logic                          nss_d;
    logic                          irq;
    logic [3:0]                    sync_q;
    logic                          busy;
    logic                          sel_out;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    spe_sync #(
        .W (`SPE_SYNC_WIDTH)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .clk_en_i  (clk_en_i),
        .d_i       ({sck_i, mosi_i, miso_i, ~slave_select_n_i}),
        .q_o       (sync_q)
    );

    wire sck_q  = sync_q[3];
    wire mosi_q = sync_q[2];
    wire miso_q = sync_q[1];
    wire nss_q  = ~sync_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding.

    wire en       = ctrl.unit_enable;
    wire master   = en & ctrl.master_enable;
    wire slave    = en & ~ctrl.master_enable;
    wire three    = ctrl.select_mode == `SPE_MODE_3WIRE;
    wire four_in  = ctrl.select_mode == `SPE_MODE_4IN;
    wire selected = three | (four_in & ~nss_q);
    wire nss_fall = nss_d & ~nss_q;
    wire m_fault  = master & four_in & ~nss_q;
    wire m_busy   = m_state == spi_engine_pkg::ST_SHIFT;
    wire half_tk  = m_busy & (div_cnt == ctrl.rate);
    wire s_edge   = slave & selected & (sck_q != sck_d);
    wire edge_ev  = master ? half_tk : s_edge;
    wire last_e   = edge_cnt == `SPE_LAST_EDGE;
    wire lead_e   = ~edge_cnt[0];
    wire data_in  = master ? miso_q : mosi_q;
    wire samp_now = edge_ev & (edge_cnt[0] == ctrl.clock_phase);
    wire sh_cpha1 = (lead_e & (edge_cnt != 4'h0)) | last_e;
    wire shift_ok = ctrl.clock_phase ? sh_cpha1 : edge_cnt[0];
    wire shift_nw = edge_ev & shift_ok;
    wire in_bit   = samp_now ? data_in : samp;
    wire [7:0] sr_shifted = {sr[6:0], in_bit};
    wire byte_done = shift_nw & last_e;
    wire xfer_busy = master ? m_busy : (edge_cnt != 4'h0);
    wire load_sr   = en & tx_full & sr_empty & ~xfer_busy & ~m_fault;
    wire start_m   = load_sr & master;
    wire wr_ok     = data_wr_i & ~tx_full;
    wire write_collision_flag_hit  = data_wr_i & tx_full;
    wire ovr_hit   = byte_done & slave & rx_full;
    wire rx_load   = byte_done & ~ovr_hit;
    wire cnt_clear = ~en | (slave & four_in & nss_fall);

    spi_engine_pkg::control_word_s next_ctrl;
    spi_engine_pkg::flags_s        next_flags;
    spi_engine_pkg::pins_s         next_pins;

    always_comb begin
        next_ctrl = ctrl_wr_i ? ctrl_i : ctrl;
        if (m_fault) begin
            next_ctrl.master_enable = 1'b0;
            next_ctrl.unit_enable   = 1'b0;
        end
    end

    // A flag set in the same cycle as its clear stays set.
    always_comb begin
        next_flags            = flags & ~spi_engine_pkg::flags_s'(flag_clr_i);
        next_flags.done       = next_flags.done | byte_done;
        next_flags.write_collision_flag       = next_flags.write_collision_flag | write_collision_flag_hit;
        next_flags.mode_fault = next_flags.mode_fault | m_fault;
        next_flags.overrun    = next_flags.overrun | ovr_hit;
    end

    always_comb begin
        next_pins.sck_o      = sck_lvl;
        next_pins.sck_oe     = master;
        next_pins.mosi_o     = sr[7];
        next_pins.mosi_oe    = master;
        next_pins.miso_o     = sr[7];
        next_pins.miso_oe    = slave & selected;
        next_pins.nss_o      = ctrl.select_mode[0];
        next_pins.nss_oe     = ctrl.select_mode[1];
        next_pins.nss_mapped = ~three;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control, flags and buffers.

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ctrl             <= '0;
            ctrl.select_mode <= `SPE_MODE_RST;
            ctrl.rate        <= `SPE_RATE_RST;
            flags            <= '0;
            irq              <= 1'b0;
            pins             <= '0;
            busy             <= 1'b0;
            sel_out          <= 1'b0;
        end else if (clk_en_i) begin
            ctrl    <= next_ctrl;
            flags   <= next_flags;
            irq     <= irq_en_i & (|next_flags);
            pins    <= next_pins;
            busy    <= m_busy | (edge_cnt != 4'h0);
            sel_out <= selected;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_buf  <= 8'h00;
            tx_full <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_ok) begin
                tx_buf  <= data_wdata_i;
                tx_full <= 1'b1;
            end else if (load_sr) begin
                tx_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_buf  <= 8'h00;
            rx_full <= 1'b0;
        end else if (clk_en_i) begin
            if (rx_load) begin
                rx_buf <= sr_shifted;
            end
            rx_full <= rx_load | (rx_full & ~data_rd_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift register, edge counter and master clock.

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sr       <= 8'h00;
            sr_empty <= 1'b1;
            samp     <= 1'b0;
        end else if (clk_en_i) begin
            if (load_sr) begin
                sr       <= tx_buf;
                sr_empty <= 1'b0;
            end else if (shift_nw) begin
                sr <= sr_shifted;
            end
            if (byte_done) begin
                sr_empty <= 1'b1;
            end
            if (samp_now) begin
                samp <= data_in;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            edge_cnt <= 4'h0;
            sck_d    <= 1'b0;
            nss_d    <= 1'b1;
        end else if (clk_en_i) begin
            sck_d <= sck_q;
            nss_d <= nss_q;
            if (cnt_clear || m_fault) begin
                edge_cnt <= 4'h0;
            end else if (edge_ev) begin
                edge_cnt <= edge_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            m_state <= spi_engine_pkg::ST_IDLE;
            div_cnt <= 8'h00;
            sck_lvl <= 1'b0;
        end else if (clk_en_i) begin
            case (m_state)
                spi_engine_pkg::ST_IDLE: begin
                    sck_lvl <= ctrl.clock_idle_level;
                    div_cnt <= 8'h00;
                    if (start_m) begin
                        m_state <= spi_engine_pkg::ST_SHIFT;
                    end
                end
                spi_engine_pkg::ST_SHIFT: begin
                    if (!master || m_fault || byte_done) begin
                        m_state <= spi_engine_pkg::ST_IDLE;
                        sck_lvl <= ctrl.clock_idle_level;
                        div_cnt <= 8'h00;
                    end else if (half_tk) begin
                        sck_lvl <= ~sck_lvl;
                        div_cnt <= 8'h00;
                    end else begin
                        div_cnt <= div_cnt + 8'h01;
                    end
                end
                default: begin
                    m_state <= spi_engine_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign ctrl_o                = ctrl;
    assign flags_o               = flags;
    assign irq_o                 = irq;
    assign rx_data_o             = rx_buf;
    assign rx_full_o             = rx_full;
    assign tx_full_o             = tx_full;
    assign busy_o                = busy;
    assign selected_o            = sel_out;
    assign sck_o                 = pins.sck_o;
    assign sck_oe_o              = pins.sck_oe;
    assign mosi_o                = pins.mosi_o;
    assign mosi_oe_o             = pins.mosi_oe;
    assign miso_o                = pins.miso_o;
    assign miso_oe_o             = pins.miso_oe;
    assign slave_select_n_o      = pins.nss_o;
    assign slave_select_n_oe_o   = pins.nss_oe;
    assign slave_select_mapped_o = pins.nss_mapped;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_MOSI_MSB: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && master |=> mosi_oe_o && mosi_o == $past(sr[7]))
        else $error("Master-out does not follow the shift register MSB.");

    AST_MISO_FLOAT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && !en |=> !miso_oe_o)
        else $error("Master-in driven while the unit is disabled.");

    AST_IGNORE_SCK: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && slave && four_in && nss_q && !ctrl_wr_i |=> $stable(edge_cnt))
        else $error("Bit counter moved while slave not selected.");

    AST_NSS_OUT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && ctrl.select_mode[1]
        |=> slave_select_n_oe_o && slave_select_n_o == $past(ctrl.select_mode[0]))
        else $error("Slave-select output does not follow the select mode.");

    AST_FAULT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && m_fault
        |=> !ctrl.unit_enable && !ctrl.master_enable && flags.mode_fault)
        else $error("Mode fault did not disable the unit.");

    AST_DONE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && byte_done |=> flags.done ##1 !clk_en_i || flags.done
        || $past(flag_clr_i[`SPE_FLG_DONE]))
        else $error("Done flag not set after the last bit.");

    AST_WRITE_COLLISION_FLAG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && data_wr_i && tx_full |=> flags.write_collision_flag && tx_buf == $past(tx_buf))
        else $error("Colliding write changed the transmit buffer.");

    AST_OVERRUN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && ovr_hit |=> flags.overrun && rx_buf == $past(rx_buf))
        else $error("Overrun byte replaced the unread receive byte.");

    AST_STICKY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i && flags.write_collision_flag && !flag_clr_i[`SPE_FLG_WRITE_COLLISION_FLAG] |=> flags.write_collision_flag)
        else $error("Write collision flag cleared by hardware.");

endmodule : spi_master_slave_engine

//--- common/spi_engine_cfg.svh
/*
 * Constants of the byte-wide SPI engine: select modes, reset values, flag positions and counts.
 * Assumes inclusion by bare name from the engine files.
 */
`ifndef SPI_ENGINE_CFG_SVH
`define SPI_ENGINE_CFG_SVH

`define SPE_MODE_3WIRE   2'h0
`define SPE_MODE_4IN     2'h1
`define SPE_MODE_RST     2'h1
`define SPE_RATE_RST     8'h04
`define SPE_LAST_EDGE    4'hf
`define SPE_FLG_DONE     0
`define SPE_FLG_WRITE_COLLISION_FLAG     1
`define SPE_FLG_MODE_FAULT_FLAG     2
`define SPE_FLG_OVR      3
`define SPE_SYNC_WIDTH   4

`endif

//--- common/spi_engine_pkg.sv
/*
 * Types of the byte-wide SPI engine: control word, sticky flags, pin drive and master states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spi_engine_pkg;

    typedef struct packed {
        logic       unit_enable;
        logic       master_enable;
        logic [1:0] select_mode;
        logic       clock_idle_level;
        logic       clock_phase;
        logic [7:0] rate;
    } control_word_s;

    typedef struct packed {
        logic overrun;
        logic mode_fault;
        logic write_collision_flag;
        logic done;
    } flags_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic nss_o;
        logic nss_oe;
        logic nss_mapped;
    } pins_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } master_state_e;

endpackage : spi_engine_pkg

//--- logic/spe_sync.sv
/*
 * Two-flop level synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to ref_clk_i.
 */
`timescale 1ns/1ps

module spe_sync #(
    parameter int W = 4
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    input  wire logic         clk_en_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            stage1 <= '0;
            q_o    <= '0;
        end else if (clk_en_i) begin
            stage1 <= d_i;
            q_o    <= stage1;
        end
    end

endmodule : spe_sync

//--- tb/spi_far_end.sv
/*
 * Far-end SPI model: a master that frames bytes, or a slave that answers one.
 * Assumes mode 0 timing and pin levels resolved by the bench.
 */
`timescale 1ns/1ps

module spi_far_end (
    input  wire logic sck_line_i,
    input  wire logic mosi_line_i,
    input  wire logic miso_line_i,
    output logic      sck_o,
    output logic      mosi_o,
    output logic      miso_o,
    output logic      nss_n_o
);
    logic       slave_role = 1'b0;
    logic [7:0] reply      = 8'h00;
    logic [7:0] got        = 8'h00;
    int         cnt        = 0;

    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        miso_o = 1'b0;
        nss_n_o = 1'b1;
    end

    // Loads the answer; its first bit shows before the first edge.
    task automatic load(input logic [7:0] b);
        reply = b;
        miso_o = b[7];
        cnt = 0;
        slave_role = 1'b1;
    endtask : load

    // Holds the select line at a level outside any frame.
    task automatic hold_sel(input logic lvl);
        nss_n_o = lvl;
    endtask : hold_sel

    always @(posedge sck_line_i) begin
        if (slave_role) begin
            got <= {got[6:0], mosi_line_i};
        end
    end

    // After the last bit the line shows the inverse of its last value.
    always @(negedge sck_line_i) begin
        if (slave_role) begin
            cnt <= cnt + 1;
            reply <= {reply[6:0], 1'b0};
            miso_o <= (cnt >= 7) ? ~miso_o : reply[6];
        end
    end

    // Frames one byte; with sel low the select line stays high.
    task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
        slave_role = 1'b0;
        nss_n_o = ~sel;
        #200;
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            #200 sck_o = 1'b1;
            rx[i] = miso_line_i;
            #200 sck_o = 1'b0;
        end
        #200 nss_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask : xfer
endmodule : spi_far_end

//--- tb/testbench.sv
/*
 * Self-checking bench of the SPI engine against the far-end model.
 * Assumes the engine resolves nothing itself: the bench merges pin drives.
 */
`timescale 1ns/1ps

module testbench;
    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] tx;
        logic [7:0] reply;
    } row_s;

    logic                          ref_clk_i    = 1'b0;
    logic                          reset_i      = 1'b1;
    logic                          clk_en_i     = 1'b1;
    logic                          ctrl_wr_i    = 1'b0;
    spi_engine_pkg::control_word_s ctrl_i       = '0;
    logic [3:0]                    flag_clr_i   = 4'h0;
    logic                          irq_en_i     = 1'b1;
    logic                          data_wr_i    = 1'b0;
    logic [7:0]                    data_wdata_i = 8'h00;
    logic                          data_rd_i    = 1'b0;
    spi_engine_pkg::control_word_s ctrl_o;
    spi_engine_pkg::flags_s        flags_o;
    logic [7:0]                    rx_data_o;
    logic                          irq_o, rx_full_o, tx_full_o, busy_o, selected_o;
    logic                          sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic                          slave_select_n_o, slave_select_n_oe_o;
    logic                          slave_select_mapped_o;
    logic                          far_sck, far_mosi, far_miso, far_nss;
    wire logic                     sck_i, mosi_i, miso_i, slave_select_n_i;
    logic [7:0]                    b;
    int                            err_count    = 0;
    int                            cmp_count    = 0;
    row_s                          rows [3]     = '{'{2'h0, 8'ha5, 8'h3c},
                                                    '{2'h2, 8'h01, 8'h80},
                                                    '{2'h3, 8'hff, 8'h00}};

    assign sck_i = sck_oe_o ? sck_o : far_sck;
    assign mosi_i = mosi_oe_o ? mosi_o : far_mosi;
    assign miso_i = miso_oe_o ? miso_o : far_miso;
    assign slave_select_n_i = slave_select_n_oe_o ? slave_select_n_o : far_nss;

    always #25 ref_clk_i = ~ref_clk_i;

    spi_master_slave_engine i_spi_master_slave_engine (
        .ref_clk_i, .reset_i, .clk_en_i, .ctrl_wr_i, .ctrl_i, .flag_clr_i, .irq_en_i,
        .data_wr_i, .data_wdata_i, .data_rd_i, .sck_i, .mosi_i, .miso_i,
        .slave_select_n_i, .ctrl_o, .flags_o, .irq_o, .rx_data_o, .rx_full_o,
        .tx_full_o, .busy_o, .selected_o, .sck_o, .sck_oe_o, .mosi_o, .mosi_oe_o,
        .miso_o, .miso_oe_o, .slave_select_n_o, .slave_select_n_oe_o,
        .slave_select_mapped_o
    );

    spi_far_end i_spi_far_end (
        .sck_line_i(sck_i), .mosi_line_i(mosi_i), .miso_line_i(miso_i),
        .sck_o(far_sck), .mosi_o(far_mosi), .miso_o(far_miso), .nss_n_o(far_nss)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic clk(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : clk

    task automatic rel;
        @(negedge ref_clk_i);
        ctrl_wr_i = 1'b0;
        data_wr_i = 1'b0;
        data_rd_i = 1'b0;
        flag_clr_i = 4'h0;
    endtask : rel

    task automatic cfg(input logic en, input logic ms, input logic [1:0] md);
        @(negedge ref_clk_i);
        ctrl_wr_i = 1'b1;
        ctrl_i = {en, ms, md, 2'b00, 8'h04};
        rel;
        clk(3);
    endtask : cfg

    task automatic wr(input logic [7:0] v);
        @(negedge ref_clk_i);
        data_wr_i = 1'b1;
        data_wdata_i = v;
    endtask : wr

    task automatic clr(input logic [3:0] m);
        @(negedge ref_clk_i);
        flag_clr_i = m;
        rel;
    endtask : clr

    task automatic rd;
        @(negedge ref_clk_i);
        data_rd_i = 1'b1;
        rel;
    endtask : rd

    task automatic wait_done;
        int n;
        n = 0;
        while (flags_o.done !== 1'b1 && n < 400) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 400) begin
            err_count++;
            $display("ERROR %0t: done flag timeout", $time);
        end
        clk(2);
    endtask : wait_done

    task automatic results;
        $display("Mismatches %0d in %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        err_count++;
        results;
    end

    initial begin
        clk(8);
        reset_i = 1'b0;
        clk(2);
        chk(ctrl_o.select_mode, 2'h1);
        chk(flags_o, 4'h0);
        for (int i = 0; i < 3; i++) begin
            cfg(1'b1, 1'b1, rows[i].mode);
            i_spi_far_end.load(rows[i].reply);
            chk(slave_select_n_oe_o, rows[i].mode[1]);
            chk(slave_select_n_o & rows[i].mode[1], rows[i].mode[0] & rows[i].mode[1]);
            chk(slave_select_mapped_o, rows[i].mode != 2'h0);
            chk(sck_o, 1'b0);
            chk(mosi_oe_o, 1'b1);
            wr(rows[i].tx);
            rel;
            wait_done;
            chk(flags_o.done, 1'b1);
            chk(rx_data_o, rows[i].reply);
            chk(i_spi_far_end.got, rows[i].tx);
            clr(4'h1);
            rd;
        end
        @(negedge ref_clk_i);
        ctrl_wr_i = 1'b1;
        ctrl_i = {1'b0, 1'b1, 2'h0, 2'b10, 8'h04};
        rel;
        clk(3);
        chk(sck_o, 1'b1);
        cfg(1'b0, 1'b0, 2'h0);
        cfg(1'b1, 1'b1, 2'h0);
        wr(8'h81);
        rel;
        clk(3);
        wr(8'h42);
        rel;
        chk(tx_full_o, 1'b1);
        chk(busy_o, 1'b1);
        wr(8'h24);
        rel;
        clk(1);
        chk(flags_o.write_collision_flag, 1'b1);
        wait_done;
        clr(4'h1);
        wait_done;
        chk(i_spi_far_end.got, 8'h42);
        chk(flags_o.write_collision_flag, 1'b1);
        chk(irq_o, 1'b1);
        clr(4'hf);
        cfg(1'b1, 1'b1, 2'h1);
        i_spi_far_end.hold_sel(1'b0);
        clk(6);
        chk(ctrl_o.unit_enable, 1'b0);
        chk(ctrl_o.master_enable, 1'b0);
        chk(flags_o.mode_fault, 1'b1);
        chk(irq_o, 1'b1);
        i_spi_far_end.hold_sel(1'b1);
        clr(4'hf);
        rd;
        cfg(1'b1, 1'b0, 2'h1);
        chk(selected_o, 1'b0);
        chk(mosi_oe_o, 1'b0);
        chk(miso_oe_o, 1'b0);
        wr(8'h96);
        rel;
        i_spi_far_end.xfer(8'h5a, 1'b1, b);
        clk(6);
        chk(flags_o.done, 1'b1);
        chk(rx_data_o, 8'h5a);
        chk(b, 8'h96);
        clr(4'h1);
        i_spi_far_end.xfer(8'hff, 1'b0, b);
        clk(6);
        chk(flags_o.done, 1'b0);
        i_spi_far_end.xfer(8'h11, 1'b1, b);
        clk(6);
        chk(flags_o.overrun, 1'b1);
        chk(rx_data_o, 8'h5a);
        chk(rx_full_o, 1'b1);
        cfg(1'b0, 1'b0, 2'h0);
        chk(miso_oe_o, 1'b0);
        rd;
        clr(4'hf);
        cfg(1'b1, 1'b0, 2'h0);
        chk(miso_oe_o, 1'b1);
        chk(selected_o, 1'b1);
        wr(8'h3c);
        rel;
        clk(3);
        chk(miso_o, 1'b0);
        i_spi_far_end.xfer(8'hc3, 1'b0, b);
        clk(6);
        chk(rx_data_o, 8'hc3);
        chk(b, 8'h3c);
        reset_i = 1'b1;
        clk(2);
        reset_i = 1'b0;
        clk(1);
        chk(flags_o, 4'h0);
        chk(ctrl_o.select_mode, 2'h1);
        chk(rx_full_o, 1'b0);
        results;
    end
endmodule : testbench
